// ---- gcpc_chk_sva.sv ----
// Assertion checker for the copper PHY control block
`timescale 1ns/1ps
`default_nettype none

module gcpc_chk #(
  parameter MINW = 25
) (
  // Clock and reset
  input wire logic        clk_in,
  input wire logic        rst_in,
  // Watched inputs
  input wire logic [1:0]  link_control_in,
  input wire logic        scr_ok_in,
  // Watched outputs
  input wire logic [11:0] tx_symb_out,
  input wire logic [1:0]  tx_mode_out,
  input wire logic        pcs_reset_out,
  input wire logic        tx_pairs_en_out,
  input wire logic        link_ok_out,
  input wire logic        config_master_out
);
  logic [1:0] mode_ff;
  logic [7:0] dwell_ff;

  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // Cycles spent in the present transmit mode
  always @(posedge clk_in) begin
    if (rst_in) begin
      mode_ff  <= 2'h0;
      dwell_ff <= 8'h00;
    end else begin
      mode_ff  <= tx_mode_out;
      dwell_ff <= (tx_mode_out != mode_ff) ? 8'h00 : dwell_ff + {7'h00, dwell_ff != 8'hff};
    end
  end

  ////////////////////////////////////////////////////////////////
  reset_out_a:
    assert property (disable iff (1'b0) rst_in |=> pcs_reset_out && !tx_pairs_en_out)
    else $error("outputs not held in reset");
  hold_len_a:
    assert property ($fell(rst_in) |-> pcs_reset_out [*8] ##[1:12] !pcs_reset_out)
    else $error("reset hold length wrong");
  neg_off_a:
    assert property (link_control_in != 2'h2 |=> !tx_pairs_en_out && tx_mode_out == 2'h0
                     && tx_symb_out == 12'h000 && !link_ok_out)
    else $error("transmitters not off outside enable");
  enter_silent_a:
    assert property (link_control_in == 2'h2 && !tx_pairs_en_out && !pcs_reset_out
                     |=> tx_pairs_en_out && tx_mode_out == 2'h0)
    else $error("enable did not enter silent");
  master_train_a:
    assert property (link_control_in == 2'h2 && tx_pairs_en_out && tx_mode_out == 2'h0
                     && config_master_out |=> tx_mode_out == 2'h1)
    else $error("master lingered in silent");
  slave_wait_a:
    assert property (link_control_in == 2'h2 && tx_pairs_en_out && tx_mode_out == 2'h0
                     && !config_master_out && !scr_ok_in |=> tx_mode_out == 2'h0)
    else $error("slave trained without lock");
  min_dwell_a:
    assert property (mode_ff != 2'h0 && tx_mode_out != 2'h0 && tx_mode_out != mode_ff
                     |-> dwell_ff >= MINW - 2)
    else $error("send state left before minimum wait");
  data_link_a:
    assert property ($rose(tx_mode_out == 2'h2) |-> link_ok_out)
    else $error("data mode without link");
endmodule

bind gcpc_top gcpc_chk #(.MINW(MINW)) i_gcpc_chk (
  .clk_in(clk_in), .rst_in(rst_in), .link_control_in(link_control_in),
  .scr_ok_in(scr_ok_in), .tx_symb_out(tx_symb_out), .tx_mode_out(tx_mode_out),
  .pcs_reset_out(pcs_reset_out), .tx_pairs_en_out(tx_pairs_en_out),
  .link_ok_out(link_ok_out), .config_master_out(config_master_out));

`default_nettype wire

// ---- gcpc_partner.sv ----
// Remote PHY model that reports its receiver status in the coding stream
`timescale 1ns/1ps
`default_nettype none

module gcpc_partner #(
  parameter PER = 6
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Bench control and link state
  input  wire logic rcvr_ok_in,
  input  wire logic hears_us_in,
  // Decoded partner status
  output var logic  stat_valid_out = 1'b0,
  output var logic  stat_ok_out = 1'b0
);
  logic [3:0] cnt_ff = 4'h0;

  // One status word every PER cycles while our signal reaches it
  always @(posedge clk_in) begin
    if (rst_in || !hears_us_in) begin
      cnt_ff         <= 4'h0;
      stat_valid_out <= 1'b0;
    end else begin
      cnt_ff         <= (cnt_ff == PER - 1) ? 4'h0 : cnt_ff + 4'h1;
      stat_valid_out <= (cnt_ff == PER - 1);
    end
    // Status bit toggles between words, so only the strobe qualifies it
    stat_ok_out <= rst_in ? 1'b0 : (stat_valid_out ? !stat_ok_out : rcvr_ok_in);
  end
endmodule

`default_nettype wire

// ---- gcpc_rcvr_stat.v ----
// Local receiver status from descrambler lock, equalizer and clock lock
`timescale 1ns/1ps
`default_nettype none

module gcpc_rcvr_stat #(
  parameter FILT = 8
) (
  // Clock and reset
  input  wire clk_in,
  input  wire rst_in,
  // Receiver conditions
  input  wire scr_ok_in,
  input  wire eq_ok_in,
  input  wire clk_lock_in,
  // Result
  output wire loc_ok_out
);

  reg  [7:0] cnt_ff;
  reg        ok_ff;
  wire       good;

  assign good = scr_ok_in & eq_ok_in & clk_lock_in;

  // OK only after FILT clean cycles, NOT_OK at once on any loss
  always @(posedge clk_in) begin
    if (rst_in || !good) begin
      cnt_ff <= 8'h00;
      ok_ff  <= 1'b0;
    end else if (cnt_ff >= FILT[7:0] - 8'h01) begin
      ok_ff <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

  assign loc_ok_out = ok_ff;

endmodule

`default_nettype wire

// ---- gcpc_regs.vh ----
// Register map, encodings and timing constants of the copper PHY control block
`ifndef GCPC_REGS_VH
`define GCPC_REGS_VH

// Register byte offsets
`define GCPC_OFS_CTRL        4'h0
`define GCPC_OFS_STATUS      4'h4
`define GCPC_OFS_EVENT       4'h8

// Control register fields
`define GCPC_CTRL_MASTER     0
`define GCPC_CTRL_SOFT_RST   1
`define GCPC_CTRL_SCR_REINIT 2
`define GCPC_CTRL_RESET      3'h0

// Status register fields
`define GCPC_ST_STATE_LSB    0
`define GCPC_ST_LINK_OK      5
`define GCPC_ST_LOC_OK       6
`define GCPC_ST_REM_OK       7
`define GCPC_ST_MODE_LSB     8
`define GCPC_ST_RST_BUSY     10

// Event register fields, write one to clear
`define GCPC_EV_LINK_DROP    0
`define GCPC_EV_RETRAIN      1
`define GCPC_EV_MAXWAIT      2
`define GCPC_EV_RESET        3'h0

// Transmit mode codes
`define GCPC_MODE_SEND_Z     2'h0
`define GCPC_MODE_SEND_I     2'h1
`define GCPC_MODE_SEND_N     2'h2

// Link control codes from auto-negotiation
`define GCPC_LC_DISABLE      2'h0
`define GCPC_LC_SCAN         2'h1
`define GCPC_LC_ENABLE       2'h2

// Timing figures
`define GCPC_CLK_PERIOD_NS   40
`define GCPC_CLK_KHZ         25000
`define GCPC_MAXWAIT_M_MS    750
`define GCPC_MAXWAIT_S_MS    350
`define GCPC_MINWAIT_NS      1000
`define GCPC_MINWAIT_CYC     ((`GCPC_MINWAIT_NS + `GCPC_CLK_PERIOD_NS - 1) / `GCPC_CLK_PERIOD_NS)
`define GCPC_MAXWAIT_M_CYC   (`GCPC_MAXWAIT_M_MS * `GCPC_CLK_KHZ)
`define GCPC_MAXWAIT_S_CYC   (`GCPC_MAXWAIT_S_MS * `GCPC_CLK_KHZ)
`define GCPC_RST_HOLD_CYC    16
`define GCPC_LOC_FILT_CYC    8

`endif

// ---- gcpc_timer.v ----
// One-shot down-counting timer with restart, stop and done level
`timescale 1ns/1ps
`default_nettype none

module gcpc_timer #(
  parameter W = 25
) (
  // Clock and reset
  input  wire         clk_in,
  input  wire         rst_in,
  // Control
  input  wire         start_in,
  input  wire         stop_in,
  input  wire [W-1:0] load_in,
  // Status
  output wire         done_out,
  output wire         run_out
);

  reg  [W-1:0] cnt_ff;
  reg          run_ff;
  reg          done_ff;

  // Stop wins over restart; done holds until restart or stop
  always @(posedge clk_in) begin
    if (rst_in || stop_in) begin
      cnt_ff  <= {W{1'b0}};
      run_ff  <= 1'b0;
      done_ff <= 1'b0;
    end else if (start_in) begin
      cnt_ff  <= load_in;
      run_ff  <= 1'b1;
      done_ff <= 1'b0;
    end else if (run_ff) begin
      cnt_ff <= cnt_ff - {{(W-1){1'b0}}, 1'b1};
      if (cnt_ff <= {{(W-1){1'b0}}, 1'b1}) begin
        run_ff  <= 1'b0;
        done_ff <= 1'b1;
      end
    end
  end

  assign done_out = done_ff;
  assign run_out  = run_ff;

endmodule

`default_nettype wire

// ---- gcpc_top.v ----
// PHY control, reset, clock select and link monitor of the copper PMA
//
// Overview of operation
// - Reset on power-on and management request
// - Hold coding reset on while reset lasts
// - Reset returns every state machine to start
// - Operating functions start after reset completes
// - Four pairs share clock, send symbols continuously
// - Master uses local clock, slave recovered
// - Transmitters off while auto-negotiation runs
// - Enable enters silent, starts maxwait, sends zeros
// - Master leaves silent for training at once
// - Slave trains only after descrambler lock
// - Training starts minwait and sends idle
// - Exchange receiver status; store partner's value
// - Leave training on minwait and local OK
// - Send states stop maxwait, restart minwait
// - Send-idle-or-data state drives send normal
// - Local loss: finish frame, return to silent
// - Remote loss: idle, report local OK
// - Remote recovers: back to idle-or-data
// - May request coding reset for scrambler
// - Link fails in negotiation, OK when reliable
// - Local status from scrambler and equalizer
// - Recovered clock stable, fed to transmit
// - Maxwait 750 ms master, 350 ms slave
// - Minwait expires one microsecond after start
// - Maxwait expiry with local loss fails link
`timescale 1ns/1ps
`default_nettype none
`include "gcpc_regs.vh"

module gcpc_top #(
  parameter MAXW_M = `GCPC_MAXWAIT_M_CYC,
  parameter MAXW_S = `GCPC_MAXWAIT_S_CYC,
  parameter MINW   = `GCPC_MINWAIT_CYC,
  parameter RST_HOLD = `GCPC_RST_HOLD_CYC,
  parameter LOC_FILT = `GCPC_LOC_FILT_CYC
) (
  // Clock and reset
  input  wire        clk_in,
  input  wire        rst_in,
  // Avalon-MM slave
  input  wire [3:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  input  wire [3:0]  avs_byteenable_in,
  output reg  [31:0] avs_readdata_out,
  output wire        avs_waitrequest_out,
  // Auto-negotiation
  input  wire [1:0]  link_control_in,
  // Receive side conditions
  input  wire        scr_ok_in,
  input  wire        eq_ok_in,
  input  wire        rx_clk_lock_in,
  input  wire        rem_stat_valid_in,
  input  wire        rem_rcvr_ok_in,
  // Coding sublayer transmit
  input  wire        frame_active_in,
  input  wire [11:0] tx_symb_in,
  output reg  [11:0] tx_symb_out,
  output reg  [1:0]  tx_mode_out,
  output reg         pcs_reset_out,
  output reg         enc_loc_ok_out,
  // Pair drivers and clocking
  output reg         tx_pairs_en_out,
  output reg         tx_clk_recov_out,
  // Status
  output reg         link_ok_out,
  output reg         loc_ok_out,
  output reg         config_master_out
);

  ////////////////////////////////////////////////////////////////////////
  // States
  localparam [4:0] S_DIS   = 5'b0_0001;
  localparam [4:0] S_SIL   = 5'b0_0010;
  localparam [4:0] S_TRN   = 5'b0_0100;
  localparam [4:0] S_IDLE  = 5'b0_1000;
  localparam [4:0] S_DATA  = 5'b1_0000;
  localparam [24:0] MAXW_M_W = MAXW_M[24:0];
  localparam [24:0] MAXW_S_W = MAXW_S[24:0];
  localparam [24:0] MINW_W   = MINW[24:0];
  localparam [7:0]  HOLD_W   = RST_HOLD[7:0];

  // True in either send state
  function is_send;
    input [4:0] st;
    begin
      is_send = st[3] | st[4];
    end
  endfunction

  reg  [4:0]  state_ff;
  reg  [4:0]  nxt_state;
  reg  [2:0]  ctrl_ff;
  reg  [2:0]  event_ff;
  reg  [2:0]  nxt_event;
  reg  [7:0]  rst_cnt_ff;
  reg         rem_ok_ff;
  reg         ack_ff;
  reg         soft_rst;
  wire        req;
  wire        wr_en;
  wire        rst_busy;
  wire        loc_ok;
  wire        lc_enable;
  wire        master;
  wire        maxw_done;
  wire        minw_done;
  wire        maxw_start;
  wire        maxw_stop;
  wire        minw_start;
  wire        minw_stop;
  wire        entry;
  wire        scr_reinit;
  wire        nxt_link_ok;

  assign master    = ctrl_ff[`GCPC_CTRL_MASTER];
  assign lc_enable = (link_control_in == `GCPC_LC_ENABLE);
  assign rst_busy  = (rst_cnt_ff != 8'h00);

  ////////////////////////////////////////////////////////////////////////
  // Avalon handshake: one wait cycle, answer on the second edge
  assign req                 = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = req & ~ack_ff;
  assign wr_en               = avs_write_in & ack_ff;

  always @(posedge clk_in) begin
    if (rst_in) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff;
    end
  end

  // Read data mux, registered; unmapped reads give zero
  always @(posedge clk_in) begin
    if (rst_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (avs_read_in && !ack_ff) begin
      case (avs_address_in)
        `GCPC_OFS_CTRL: begin
          avs_readdata_out <= {29'h0000_0000, ctrl_ff};
        end
        `GCPC_OFS_STATUS: begin
          avs_readdata_out <= {21'h00_0000, rst_busy, tx_mode_out, rem_ok_ff,
                               loc_ok_out, link_ok_out, state_ff};
        end
        `GCPC_OFS_EVENT: begin
          avs_readdata_out <= {29'h0000_0000, event_ff};
        end
        default: begin
          avs_readdata_out <= 32'h0000_0000;
        end
      endcase
    end
  end

  // Control register; soft reset bit is a self-clearing request
  always @(posedge clk_in) begin
    soft_rst <= 1'b0;
    if (rst_in) begin
      ctrl_ff  <= `GCPC_CTRL_RESET;
      soft_rst <= 1'b0;
    end else if (wr_en && avs_address_in == `GCPC_OFS_CTRL && avs_byteenable_in[0]) begin
      ctrl_ff[`GCPC_CTRL_MASTER]     <= avs_writedata_in[`GCPC_CTRL_MASTER];
      ctrl_ff[`GCPC_CTRL_SCR_REINIT] <= avs_writedata_in[`GCPC_CTRL_SCR_REINIT];
      soft_rst <= avs_writedata_in[`GCPC_CTRL_SOFT_RST];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reset function: power-on or management request, held RST_HOLD cycles
  always @(posedge clk_in) begin
    if (rst_in || soft_rst) begin
      rst_cnt_ff <= HOLD_W;
    end else if (rst_busy) begin
      rst_cnt_ff <= rst_cnt_ff - 8'h01;
    end
  end

  // Coding reset on while reset holds, or one-cycle scrambler reinit
  assign scr_reinit = ctrl_ff[`GCPC_CTRL_SCR_REINIT] & state_ff[0] & nxt_state[1];

  always @(posedge clk_in) begin
    if (rst_in) begin
      pcs_reset_out <= 1'b1;
    end else begin
      pcs_reset_out <= soft_rst | rst_busy | scr_reinit;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Local receiver status and stored partner status
  gcpc_rcvr_stat #(
    .FILT (LOC_FILT)
  ) u_rcvr_stat (
    .clk_in      (clk_in),
    .rst_in      (rst_in | rst_busy),
    .scr_ok_in   (scr_ok_in),
    .eq_ok_in    (eq_ok_in),
    .clk_lock_in (rx_clk_lock_in),
    .loc_ok_out  (loc_ok)
  );

  always @(posedge clk_in) begin
    if (rst_in || rst_busy || !lc_enable) begin
      rem_ok_ff <= 1'b0;
    end else if (rem_stat_valid_in) begin
      rem_ok_ff <= rem_rcvr_ok_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Timers
  assign entry      = (nxt_state != state_ff);
  assign maxw_start = entry & nxt_state[1];
  assign maxw_stop  = (entry & is_send(nxt_state)) | nxt_state[0];
  assign minw_start = entry & (nxt_state[2] | is_send(nxt_state));
  assign minw_stop  = nxt_state[0];

  gcpc_timer #(
    .W (25)
  ) u_maxwait (
    .clk_in   (clk_in),
    .rst_in   (rst_in | rst_busy),
    .start_in (maxw_start),
    .stop_in  (maxw_stop),
    .load_in  (master ? MAXW_M_W : MAXW_S_W),
    .done_out (maxw_done),
    .run_out  ()
  );

  gcpc_timer #(
    .W (25)
  ) u_minwait (
    .clk_in   (clk_in),
    .rst_in   (rst_in | rst_busy),
    .start_in (minw_start),
    .stop_in  (minw_stop),
    .load_in  (MINW_W),
    .done_out (minw_done),
    .run_out  ()
  );

  ////////////////////////////////////////////////////////////////////////
  // PHY control next state
  always @* begin
    nxt_state = state_ff;
    if (!lc_enable) begin
      nxt_state = S_DIS;
    end else begin
      case (state_ff)
        S_DIS: begin
          nxt_state = S_SIL;
        end
        S_SIL: begin
          if (master) begin
            nxt_state = S_TRN;
          end else if (scr_ok_in) begin
            nxt_state = S_TRN;
          end
        end
        S_TRN: begin
          if (minw_done && loc_ok) begin
            nxt_state = rem_ok_ff ? S_DATA : S_IDLE;
          end
        end
        S_IDLE: begin
          if (minw_done && !loc_ok && !frame_active_in) begin
            nxt_state = S_SIL;
          end else if (minw_done && loc_ok && rem_ok_ff) begin
            nxt_state = S_DATA;
          end
        end
        S_DATA: begin
          if (minw_done && !loc_ok && !frame_active_in) begin
            nxt_state = S_SIL;
          end else if (minw_done && loc_ok && !rem_ok_ff) begin
            nxt_state = S_IDLE;
          end
        end
        default: begin
          nxt_state = S_DIS;
        end
      endcase
    end
  end

  // State register, held in disabled until reset completes
  always @(posedge clk_in) begin
    if (rst_in || rst_busy) begin
      state_ff <= S_DIS;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmit mode, pair enable, clock select and symbol path
  always @(posedge clk_in) begin
    if (rst_in || rst_busy) begin
      tx_mode_out       <= `GCPC_MODE_SEND_Z;
      tx_pairs_en_out   <= 1'b0;
      tx_clk_recov_out  <= 1'b0;
      config_master_out <= 1'b0;
      enc_loc_ok_out    <= 1'b0;
      loc_ok_out        <= 1'b0;
      tx_symb_out       <= 12'h000;
    end else begin
      tx_pairs_en_out   <= ~nxt_state[0];
      tx_clk_recov_out  <= ~master;
      config_master_out <= master;
      loc_ok_out        <= loc_ok;
      enc_loc_ok_out    <= nxt_state[3] | loc_ok;
      if (nxt_state[4]) begin
        tx_mode_out <= `GCPC_MODE_SEND_N;
      end else if (nxt_state[2] || nxt_state[3]) begin
        tx_mode_out <= `GCPC_MODE_SEND_I;
      end else begin
        tx_mode_out <= `GCPC_MODE_SEND_Z;
      end
      // All four pairs advance together on the one symbol clock
      if (nxt_state[0] || nxt_state[1]) begin
        tx_symb_out <= 12'h000;
      end else begin
        tx_symb_out <= tx_symb_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Link monitor
  assign nxt_link_ok = lc_enable & ~(maxw_done & ~loc_ok) &
                       (link_ok_out ? loc_ok : (is_send(nxt_state) & loc_ok));

  always @(posedge clk_in) begin
    if (rst_in || rst_busy) begin
      link_ok_out <= 1'b0;
    end else begin
      link_ok_out <= nxt_link_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky events, write one to clear, a new event wins over the clear
  always @* begin
    nxt_event = event_ff;
    if (wr_en && avs_address_in == `GCPC_OFS_EVENT && avs_byteenable_in[0]) begin
      nxt_event = event_ff & ~avs_writedata_in[2:0];
    end
    if (link_ok_out && !nxt_link_ok) begin
      nxt_event[`GCPC_EV_LINK_DROP] = 1'b1;
    end
    if (is_send(state_ff) && nxt_state[1]) begin
      nxt_event[`GCPC_EV_RETRAIN] = 1'b1;
    end
    if (maxw_done && !loc_ok) begin
      nxt_event[`GCPC_EV_MAXWAIT] = 1'b1;
    end
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      event_ff <= `GCPC_EV_RESET;
    end else begin
      event_ff <= nxt_event;
    end
  end

endmodule

`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the copper PHY control block
`timescale 1ns/1ps
`default_nettype none

module tb;
  localparam int MINW = 25;
  // Design inputs
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [3:0]  avs_address_in = 4'h0;
  logic        avs_read_in = 1'b0;
  logic        avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0000_0000;
  logic [1:0]  link_control_in = 2'h0;
  logic        scr_ok_in = 1'b0;
  logic        eq_ok_in = 1'b0;
  logic        rx_clk_lock_in = 1'b0;
  logic        frame_active_in = 1'b0;
  logic [11:0] tx_symb_in = 12'h000;
  logic        rem_stat_valid_in;
  logic        rem_rcvr_ok_in;
  // Design outputs and bench state
  logic [31:0] avs_readdata_out, rd;
  logic [11:0] tx_symb_out;
  logic [1:0]  tx_mode_out;
  logic        avs_waitrequest_out, pcs_reset_out, enc_loc_ok_out, tx_pairs_en_out;
  logic        tx_clk_recov_out, link_ok_out, loc_ok_out, config_master_out;
  logic        rem_ok_set = 1'b0;
  logic        p1;
  logic [1:0]  codes [3] = '{2'h0, 2'h1, 2'h3};
  int          error_cnt = 0;
  int          checked = 0;
  int          n;

  // Block with shortened maxwait counts, and the remote PHY
  gcpc_top #(.MAXW_M(200), .MAXW_S(100), .MINW(MINW)) i_gcpc_top (
    .clk_in(clk_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(4'hf),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .link_control_in(link_control_in), .scr_ok_in(scr_ok_in), .eq_ok_in(eq_ok_in),
    .rx_clk_lock_in(rx_clk_lock_in), .rem_stat_valid_in(rem_stat_valid_in),
    .rem_rcvr_ok_in(rem_rcvr_ok_in), .frame_active_in(frame_active_in),
    .tx_symb_in(tx_symb_in), .tx_symb_out(tx_symb_out), .tx_mode_out(tx_mode_out),
    .pcs_reset_out(pcs_reset_out), .enc_loc_ok_out(enc_loc_ok_out),
    .tx_pairs_en_out(tx_pairs_en_out), .tx_clk_recov_out(tx_clk_recov_out),
    .link_ok_out(link_ok_out), .loc_ok_out(loc_ok_out),
    .config_master_out(config_master_out));
  gcpc_partner i_gcpc_partner (
    .clk_in(clk_in), .rst_in(rst_in), .rcvr_ok_in(rem_ok_set),
    .hears_us_in(tx_pairs_en_out), .stat_valid_out(rem_stat_valid_in),
    .stat_ok_out(rem_rcvr_ok_in));

  // 25 MHz clock
  always #20 clk_in = ~clk_in;

  ////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Outputs are looked at on the falling edge, where they are settled
  task automatic tick(input int k);
    repeat (k) @(negedge clk_in);
  endtask

  // One Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_in);
    avs_address_in   <= a;
    avs_writedata_in <= d;
    avs_write_in     <= wr;
    avs_read_in      <= !wr;
    i = 0;
    do begin
      @(posedge clk_in);
      i++;
    end while (avs_waitrequest_out !== 1'b0 && i < 20);
    if (avs_waitrequest_out !== 1'b0) begin
      error_cnt++;
      print_verdict();
    end
    rd = avs_readdata_out;
    avs_read_in  <= 1'b0;
    avs_write_in <= 1'b0;
  endtask

  task automatic wait_mode(input logic [1:0] m, input int lim);
    n = 0;
    while (tx_mode_out !== m && n < lim) begin
      @(negedge clk_in);
      n++;
    end
    chk(32'(tx_mode_out), 32'(m));
    if (tx_mode_out !== m) print_verdict();
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    bus(1'b0, 4'h4, 32'h0000_0000);
    chk(rd & 32'h0000_07ff, 32'h0000_0401);
    tick(20);
    chk(32'(pcs_reset_out), 32'h0000_0000);
    bus(1'b1, 4'hc, 32'hffff_ffff);
    bus(1'b0, 4'hc, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    bus(1'b0, 4'h0, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    // Master bring-up to data mode
    bus(1'b1, 4'h0, 32'h0000_0001);
    @(posedge clk_in);
    scr_ok_in <= 1'b1;
    eq_ok_in <= 1'b1;
    rx_clk_lock_in <= 1'b1;
    rem_ok_set <= 1'b1;
    tx_symb_in <= 12'ha5c;
    link_control_in <= 2'h2;
    tick(2);
    chk(32'({tx_pairs_en_out, tx_mode_out}), 32'h0000_0004);
    tick(1);
    chk(32'({tx_mode_out, tx_clk_recov_out, tx_symb_out}), 32'h0000_2a5c);
    wait_mode(2'h2, 60);
    chk(32'(n >= MINW - 2), 32'h0000_0001);
    bus(1'b0, 4'h4, 32'h0000_0000);
    chk(rd & 32'h0000_07ff, 32'h0000_02f0);
    // Partner loses and regains its receiver
    @(posedge clk_in) rem_ok_set <= 1'b0;
    wait_mode(2'h1, 60);
    chk(32'(enc_loc_ok_out), 32'h0000_0001);
    @(posedge clk_in) rem_ok_set <= 1'b1;
    wait_mode(2'h2, 60);
    // Local loss during a frame, then maxwait expiry
    @(posedge clk_in);
    frame_active_in <= 1'b1;
    eq_ok_in <= 1'b0;
    tick(40);
    chk(32'({tx_mode_out, link_ok_out, loc_ok_out}), 32'h0000_0008);
    @(posedge clk_in) frame_active_in <= 1'b0;
    wait_mode(2'h0, 10);
    tick(150);
    bus(1'b0, 4'h8, 32'h0000_0000);
    chk(rd, 32'h0000_0003);
    bus(1'b1, 4'h8, 32'h0000_0003);
    tick(60);
    bus(1'b0, 4'h8, 32'h0000_0000);
    chk(rd, 32'h0000_0004);
    // Every code other than enable turns the transmitters off
    foreach (codes[k]) begin
      @(posedge clk_in) link_control_in <= codes[k];
      tick(2);
      chk(32'({tx_pairs_en_out, tx_mode_out, link_ok_out}), 32'h0000_0000);
      @(posedge clk_in) link_control_in <= 2'h2;
      tick(2);
      chk(32'(tx_pairs_en_out), 32'h0000_0001);
    end
    // Slave with scrambler reinit
    @(posedge clk_in) link_control_in <= 2'h0;
    bus(1'b1, 4'h0, 32'h0000_0004);
    @(posedge clk_in);
    scr_ok_in <= 1'b0;
    eq_ok_in <= 1'b1;
    link_control_in <= 2'h2;
    tick(2);
    p1 = pcs_reset_out;
    tick(1);
    chk(32'(p1 | pcs_reset_out), 32'h0000_0001);
    tick(20);
    chk(32'({tx_mode_out, tx_clk_recov_out}), 32'h0000_0001);
    @(posedge clk_in) scr_ok_in <= 1'b1;
    wait_mode(2'h1, 10);
    // Soft reset from software
    bus(1'b1, 4'h0, 32'h0000_0006);
    tick(3);
    chk(32'({pcs_reset_out, tx_pairs_en_out, tx_mode_out}), 32'h0000_0008);
    bus(1'b0, 4'h0, 32'h0000_0000);
    chk(rd, 32'h0000_0004);
    print_verdict();
  end
endmodule

`default_nettype wire
